/* File: sib_segment_field_decode_and_id_query.sv */
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] Wide selector 000-101 maps ES through GS
// [RULE2] Narrow selector picks ES, CS, SS, DS
// [RULE3] Scale bits multiply index by 1,2,4,8
// [RULE4] Index order EAX..EDI, 100 means none
// [RULE5] Stream keeps scale 00 with no index
// [RULE6] Address is base, scaled index, mod displacement
// [RULE7] Base 100 ESP/SS, 101 mod00 d32/DS
// [RULE8] Mod from mod r/m, base from s-i-b
// [RULE9] Identification runs only when enable bit set
// [RULE10] Function 0 returns vendor string in EBX,EDX,ECX
// [RULE11] Function 1 returns two identification code bytes
// [RULE12] Feature bits 0,2,4,5,8,13,15,23 set
// [RULE13] All other feature bits read zero
// [RULE14] S-i-b only for r/m 100, mod not 11
// [RULE15] Undefined wide selector raises invalid opcode
module sib_segment_field_decode_and_id_query
#(
    parameter int DATA_W = 32,
    parameter int GPR_N = 8
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [sib_decode_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    input wire logic dec_valid_i,
    input wire logic addr32_i,
    input wire logic [7:0] modrm_i,
    input wire logic [7:0] sib_i,
    input wire logic [31:0] disp_i,
    input wire logic [GPR_N-1:0][31:0] gpr_i,
    input wire logic seg_wide_valid_i,
    input wire logic [2:0] segment_select_wide_i,
    input wire logic seg_narrow_valid_i,
    input wire logic [1:0] segment_select_narrow_i,
    output logic ea_valid_o,
    output logic [31:0] ea_o,
    output logic [2:0] ea_seg_o,
    output logic ea_undef_o,
    output logic seg_valid_o,
    output logic [2:0] seg_o,
    output logic invalid_opcode_o
);
    import sib_decode_pkg::*;

    // ==========================================================
    // Parameter checks
    // Three-bit fields fit only eight 32-bit words
    if (DATA_W != 32) begin : g_check_data_w
        $error("DATA_W must be 32");
    end
    if (GPR_N != 8) begin : g_check_gpr_n
        $error("GPR_N must be 8");
    end
    if (ADDR_W != 5) begin : g_check_addr_w
        $error("ADDR_W must be 5");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0] rdata;
        logic id_enable;
        logic [31:0] id_func;
        logic [31:0] id_eax;
        logic [31:0] id_ebx;
        logic [31:0] id_ecx;
        logic [31:0] id_edx;
        logic id_done;
        logic id_refused;
        logic bad_seg;
        logic ea_undef_sticky;
        logic [31:0] last_ea;
        logic ea_valid;
        logic [31:0] ea;
        logic [2:0] ea_seg;
        logic ea_undef;
        logic seg_valid;
        logic [2:0] seg;
        logic invalid_opcode;
    } state_t;

    // Enable comes up clear, so an early query faults
    localparam state_t STATE_RESET = '{
        rdata: WORD_ZERO,
        id_enable: CTRL_RESET[CTRL_ID_EN_BIT],
        id_func: WORD_ZERO,
        id_eax: WORD_ZERO,
        id_ebx: WORD_ZERO,
        id_ecx: WORD_ZERO,
        id_edx: WORD_ZERO,
        id_done: 1'h0,
        id_refused: 1'h0,
        bad_seg: 1'h0,
        ea_undef_sticky: 1'h0,
        last_ea: WORD_ZERO,
        ea_valid: 1'h0,
        ea: WORD_ZERO,
        ea_seg: 3'(SEG_DS),
        ea_undef: 1'h0,
        seg_valid: 1'h0,
        seg: 3'(SEG_NONE),
        invalid_opcode: 1'h0
    };

    state_t state_ff;
    state_t nxt_state;

    // ==========================================================
    // Addressing field decode
    logic sib_used;
    logic [1:0] scale_shift;
    logic [2:0] index_sel;
    logic index_used;
    logic [2:0] base_sel;
    logic base_used;
    seg_t sib_seg;
    disp_t disp_kind;
    logic sib_undef;

    sib_field_decode u_sib_field_decode (
        .addr32_i(addr32_i),
        .mod_i(modrm_i[7:6]),
        .rm_i(modrm_i[2:0]),
        .sib_i(sib_i),
        .sib_used_o(sib_used),
        .scale_shift_o(scale_shift),
        .index_sel_o(index_sel),
        .index_used_o(index_used),
        .base_sel_o(base_sel),
        .base_used_o(base_used),
        .seg_o(sib_seg),
        .disp_o(disp_kind),
        .ea_undef_o(sib_undef)
    );

    // ==========================================================
    // Identification answer table
    logic [31:0] tbl_eax;
    logic [31:0] tbl_ebx;
    logic [31:0] tbl_ecx;
    logic [31:0] tbl_edx;

    // Looked up from write data, so the answer lands with the write
    id_query_table u_id_query_table (
        .func_i(reg_wdata_i),
        .eax_o(tbl_eax),
        .ebx_o(tbl_ebx),
        .ecx_o(tbl_ecx),
        .edx_o(tbl_edx)
    );

    // ==========================================================
    // Effective address arithmetic
    logic [31:0] base_val;
    logic [31:0] index_val;
    logic [31:0] scaled_index;
    logic [31:0] disp_val;
    logic [31:0] ea_sum;

    // No forwarding: gpr_i must be settled in the decode cycle
    always_comb begin
        base_val = base_used ? gpr_i[base_sel] : WORD_ZERO; // [RULE7]
        index_val = index_used ? gpr_i[index_sel] : WORD_ZERO; // [RULE4]
        scaled_index = index_val << scale_shift; // [RULE3]
        case (disp_kind) // [RULE6]
            DISP_8: disp_val = {{24{disp_i[7]}}, disp_i[7:0]};
            DISP_32: disp_val = disp_i;
            default: disp_val = WORD_ZERO;
        endcase
        // Wraps modulo 2^32 as the address unit does
        ea_sum = base_val + scaled_index + disp_val; // [RULE6]
    end

    // ==========================================================
    // Segment selector decode
    logic wide_defined;
    logic [2:0] wide_code;
    logic [2:0] narrow_code;

    always_comb begin
        wide_defined = 1'b1;
        case (segment_select_wide_i) // [RULE1]
            3'h0: wide_code = 3'(SEG_ES);
            3'h1: wide_code = 3'(SEG_CS);
            3'h2: wide_code = 3'(SEG_SS);
            3'h3: wide_code = 3'(SEG_DS);
            3'h4: wide_code = 3'(SEG_FS);
            3'h5: wide_code = 3'(SEG_GS);
            default: begin
                wide_code = 3'(SEG_NONE);
                wide_defined = 1'b0;
            end
        endcase
        case (segment_select_narrow_i) // [RULE2]
            2'h0: narrow_code = 3'(SEG_ES);
            2'h1: narrow_code = 3'(SEG_CS);
            2'h2: narrow_code = 3'(SEG_SS);
            default: narrow_code = 3'(SEG_DS);
        endcase
    end

    // ==========================================================
    // Register access decode
    logic wr_ctrl;
    logic wr_func;
    logic wr_status;

    assign wr_ctrl = reg_we_i && (reg_addr_i == REG_CTRL);
    assign wr_func = reg_we_i && (reg_addr_i == REG_ID_FUNC);
    assign wr_status = reg_we_i && (reg_addr_i == REG_STATUS);

    logic [31:0] status_word;

    always_comb begin
        status_word = WORD_ZERO;
        status_word[ST_ID_DONE_BIT] = state_ff.id_done;
        status_word[ST_ID_REFUSED_BIT] = state_ff.id_refused;
        status_word[ST_BAD_SEG_BIT] = state_ff.bad_seg;
        status_word[ST_EA_UNDEF_BIT] = state_ff.ea_undef_sticky;
    end

    // ==========================================================
    // Read multiplexer
    logic [31:0] read_word;

    always_comb begin
        case (reg_addr_i)
            REG_CTRL: read_word = {31'h0, state_ff.id_enable};
            REG_ID_FUNC: read_word = state_ff.id_func;
            REG_ID_EAX: read_word = state_ff.id_eax;
            REG_ID_EBX: read_word = state_ff.id_ebx;
            REG_ID_ECX: read_word = state_ff.id_ecx;
            REG_ID_EDX: read_word = state_ff.id_edx;
            REG_STATUS: read_word = status_word;
            REG_LAST_EA: read_word = state_ff.last_ea;
            default: read_word = WORD_ZERO;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;

        // Read data stand one cycle, zero otherwise
        nxt_state.rdata = reg_re_i ? read_word : WORD_ZERO;

        if (wr_ctrl) begin
            nxt_state.id_enable = reg_wdata_i[CTRL_ID_EN_BIT];
        end

        // Status bits clear by writing one; a same-cycle set wins
        if (wr_status) begin
            if (reg_wdata_i[ST_ID_DONE_BIT]) begin
                nxt_state.id_done = 1'b0;
            end
            if (reg_wdata_i[ST_ID_REFUSED_BIT]) begin
                nxt_state.id_refused = 1'b0;
            end
            if (reg_wdata_i[ST_BAD_SEG_BIT]) begin
                nxt_state.bad_seg = 1'b0;
            end
            if (reg_wdata_i[ST_EA_UNDEF_BIT]) begin
                nxt_state.ea_undef_sticky = 1'b0;
            end
        end

        // Writing the function word issues the query
        nxt_state.invalid_opcode = 1'b0;
        if (wr_func) begin
            nxt_state.id_func = reg_wdata_i;
            if (state_ff.id_enable) begin // [RULE9]
                nxt_state.id_eax = tbl_eax; // [RULE11]
                nxt_state.id_ebx = tbl_ebx; // [RULE10]
                nxt_state.id_ecx = tbl_ecx; // [RULE10]
                nxt_state.id_edx = tbl_edx; // [RULE12]
                nxt_state.id_done = 1'b1;
            end else begin
                // Disabled query leaves results untouched and faults
                nxt_state.id_refused = 1'b1; // [RULE9]
                nxt_state.invalid_opcode = 1'b1;
            end
        end

        // Address form, one cycle behind the decode strobe
        nxt_state.ea_valid = dec_valid_i && sib_used; // [RULE14]
        nxt_state.ea_undef = 1'b0;
        if (dec_valid_i && sib_used) begin
            nxt_state.ea = ea_sum; // [RULE6]
            nxt_state.ea_seg = 3'(sib_seg); // [RULE7]
            nxt_state.ea_undef = sib_undef; // [RULE5]
            nxt_state.last_ea = ea_sum;
            if (sib_undef) begin
                nxt_state.ea_undef_sticky = 1'b1;
            end
        end

        // Segment selection, wide form has priority
        // A narrow strobe beside a wide one is dropped, not held
        nxt_state.seg_valid = 1'b0;
        if (seg_wide_valid_i) begin
            nxt_state.seg = wide_code; // [RULE1]
            nxt_state.seg_valid = wide_defined;
            if (!wide_defined) begin
                nxt_state.invalid_opcode = 1'b1; // [RULE15]
                nxt_state.bad_seg = 1'b1; // [RULE15]
            end
        end else if (seg_narrow_valid_i) begin
            nxt_state.seg = narrow_code; // [RULE2]
            nxt_state.seg_valid = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= STATE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign reg_rdata_o = state_ff.rdata;
    assign ea_valid_o = state_ff.ea_valid;
    assign ea_o = state_ff.ea;
    assign ea_seg_o = state_ff.ea_seg;
    assign ea_undef_o = state_ff.ea_undef;
    assign seg_valid_o = state_ff.seg_valid;
    assign seg_o = state_ff.seg;
    assign invalid_opcode_o = state_ff.invalid_opcode;

endmodule
`default_nettype wire

/* File: sib_decode_pkg.sv */
`default_nettype none
package sib_decode_pkg;

    // ==========================================================
    // Register map, byte addresses of 32-bit words
    localparam int ADDR_W = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ID_FUNC = 5'h04;
    localparam logic [4:0] REG_ID_EAX = 5'h08;
    localparam logic [4:0] REG_ID_EBX = 5'h0C;
    localparam logic [4:0] REG_ID_ECX = 5'h10;
    localparam logic [4:0] REG_ID_EDX = 5'h14;
    localparam logic [4:0] REG_STATUS = 5'h18;
    localparam logic [4:0] REG_LAST_EA = 5'h1C;

    // ==========================================================
    // Field positions and reset values
    localparam int CTRL_ID_EN_BIT = 0;
    localparam int ST_ID_DONE_BIT = 0;
    localparam int ST_ID_REFUSED_BIT = 1;
    localparam int ST_BAD_SEG_BIT = 2;
    localparam int ST_EA_UNDEF_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ==========================================================
    // Addressing field codes
    localparam logic [1:0] MOD_NODISP = 2'h0;
    localparam logic [1:0] MOD_DISP8 = 2'h1;
    localparam logic [1:0] MOD_DISP32 = 2'h2;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam logic [2:0] RM_SIB = 3'h4;
    localparam logic [2:0] INDEX_NONE = 3'h4;
    localparam logic [2:0] BASE_ESP = 3'h4;
    localparam logic [2:0] BASE_EBP = 3'h5;
    localparam logic [1:0] SCALE_ONE = 2'h0;

    typedef enum logic [2:0] {SEG_ES, SEG_CS, SEG_SS, SEG_DS, SEG_FS, SEG_GS, SEG_NONE} seg_t;
    typedef enum logic [1:0] {DISP_NONE, DISP_8, DISP_32} disp_t;

    // ==========================================================
    // Identification query
    localparam logic [31:0] ID_FUNC_VENDOR = 32'h0000_0000;
    localparam logic [31:0] ID_FUNC_INFO = 32'h0000_0001;
    localparam int FEAT_FPU = 0;
    localparam int FEAT_IOBP = 2;
    localparam int FEAT_TSC = 4;
    localparam int FEAT_MSR = 5;
    localparam int FEAT_CX8 = 8;
    localparam int FEAT_PGE = 13;
    localparam int FEAT_CMOV = 15;
    localparam int FEAT_PMUL = 23;
    localparam logic [31:0] FEAT_WORD = (32'h1 << FEAT_FPU) | (32'h1 << FEAT_IOBP)
        | (32'h1 << FEAT_TSC) | (32'h1 << FEAT_MSR) | (32'h1 << FEAT_CX8)
        | (32'h1 << FEAT_PGE) | (32'h1 << FEAT_CMOV) | (32'h1 << FEAT_PMUL);

endpackage
`default_nettype wire

/* File: sib_field_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module sib_field_decode
    import sib_decode_pkg::*;
(
    input wire logic addr32_i,
    input wire logic [1:0] mod_i,
    input wire logic [2:0] rm_i,
    input wire logic [7:0] sib_i,
    output logic sib_used_o,
    output logic [1:0] scale_shift_o,
    output logic [2:0] index_sel_o,
    output logic index_used_o,
    output logic [2:0] base_sel_o,
    output logic base_used_o,
    output seg_t seg_o,
    output disp_t disp_o,
    output logic ea_undef_o
);
    logic [2:0] base;

    // ==========================================================
    // Field split
    assign sib_used_o = addr32_i && (rm_i == RM_SIB) && (mod_i != MOD_REG); // [RULE14]
    assign scale_shift_o = sib_i[7:6]; // [RULE3]
    assign index_sel_o = sib_i[5:3];
    assign index_used_o = (sib_i[5:3] != INDEX_NONE); // [RULE4]
    assign base = sib_i[2:0]; // [RULE8]
    assign base_sel_o = base;
    // Flagged only; the instruction stream owns keeping this legal
    assign ea_undef_o = !index_used_o && (sib_i[7:6] != SCALE_ONE); // [RULE5]

    // ==========================================================
    // Base and displacement form
    assign base_used_o = !((base == BASE_EBP) && (mod_i == MOD_NODISP)); // [RULE7]
    assign seg_o = ((base == BASE_ESP) || ((base == BASE_EBP) && (mod_i != MOD_NODISP)))
        ? SEG_SS : SEG_DS; // [RULE7]
    always_comb begin
        case (mod_i) // [RULE6]
            MOD_DISP8: disp_o = DISP_8;
            MOD_DISP32: disp_o = DISP_32;
            default: disp_o = (base == BASE_EBP) ? DISP_32 : DISP_NONE; // [RULE7]
        endcase
    end
endmodule
`default_nettype wire

/* File: id_query_table.sv */
`timescale 1ns/1ps
`default_nettype none
module id_query_table
    import sib_decode_pkg::*;
#(
    // Arbitrary neutral identity values, twelve ASCII characters
    parameter logic [31:0] VENDOR_B = 32'h7475654E,
    parameter logic [31:0] VENDOR_D = 32'h436C6172,
    parameter logic [31:0] VENDOR_C = 32'h3165726F,
    // Arbitrary neutral identification codes
    parameter logic [7:0] ID_CODE_LO = 8'h0A,
    parameter logic [7:0] ID_CODE_HI = 8'h0B
)
(
    input wire logic [31:0] func_i,
    output logic [31:0] eax_o,
    output logic [31:0] ebx_o,
    output logic [31:0] ecx_o,
    output logic [31:0] edx_o
);
    // ==========================================================
    // Answer table
    always_comb begin
        eax_o = WORD_ZERO;
        ebx_o = WORD_ZERO;
        ecx_o = WORD_ZERO;
        edx_o = WORD_ZERO;
        if (func_i == ID_FUNC_VENDOR) begin
            ebx_o = VENDOR_B; // [RULE10]
            edx_o = VENDOR_D; // [RULE10]
            ecx_o = VENDOR_C; // [RULE10]
        end else if (func_i == ID_FUNC_INFO) begin
            eax_o = {16'h0000, ID_CODE_HI, ID_CODE_LO}; // [RULE11]
            // Cleared and undefined bits stay zero by construction
            edx_o = FEAT_WORD; // [RULE12] [RULE13]
        end
    end
endmodule
`default_nettype wire

/* File: sib_decode_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sib_decode_props (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic dec_valid_i,
    input wire logic addr32_i,
    input wire logic [7:0] modrm_i,
    input wire logic [7:0] sib_i,
    input wire logic seg_wide_valid_i,
    input wire logic [2:0] segment_select_wide_i,
    input wire logic seg_narrow_valid_i,
    input wire logic [1:0] segment_select_narrow_i,
    input wire logic ea_valid_o,
    input wire logic [2:0] ea_seg_o,
    input wire logic ea_undef_o,
    input wire logic seg_valid_o,
    input wire logic [2:0] seg_o,
    input wire logic invalid_opcode_o
);
    import sib_decode_pkg::*;
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic sib_hit;
    assign sib_hit = dec_valid_i && addr32_i && modrm_i[2:0] == RM_SIB && modrm_i[7:6] != MOD_REG;
    AST_SIB_TAKEN: assert property (sib_hit |=> ea_valid_o)
        else $error("sib form gave no address");
    AST_NO_SIB: assert property (!sib_hit |=> !ea_valid_o)
        else $error("address from a non sib form");
    AST_EA_SEG: assert property (ea_valid_o |-> ea_seg_o == (($past(sib_i[2:0]) == BASE_ESP
        || ($past(sib_i[2:0]) == BASE_EBP && $past(modrm_i[7:6]) != MOD_NODISP)) ? 3'h2 : 3'h3))
        else $error("wrong address segment");
    AST_EA_UNDEF: assert property (ea_valid_o |-> ea_undef_o ==
        ($past(sib_i[5:3]) == INDEX_NONE && $past(sib_i[7:6]) != SCALE_ONE))
        else $error("undefined address flag wrong");
    AST_WIDE_OK: assert property (seg_wide_valid_i && segment_select_wide_i < 3'h6 |=>
        seg_valid_o && !invalid_opcode_o && seg_o == $past(segment_select_wide_i))
        else $error("wide selector decode wrong");
    AST_WIDE_BAD: assert property (seg_wide_valid_i && segment_select_wide_i > 3'h5 |=>
        invalid_opcode_o && !seg_valid_o && seg_o == 3'h6)
        else $error("undefined wide selector accepted");
    AST_NARROW: assert property (seg_narrow_valid_i && !seg_wide_valid_i |=>
        seg_valid_o && seg_o == {1'h0, $past(segment_select_narrow_i)})
        else $error("narrow selector decode wrong");
    AST_SEG_HOLD: assert property (!seg_wide_valid_i && !seg_narrow_valid_i |=>
        !seg_valid_o && $stable(seg_o))
        else $error("segment output moved without request");
    cover property (ea_valid_o && ea_undef_o);
    cover property (invalid_opcode_o && !seg_valid_o);
    cover property (seg_valid_o && seg_o == 3'h5);
endmodule
`default_nettype wire

/* File: sib_segment_field_decode_and_id_query_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sib_segment_field_decode_and_id_query_bench;
    import sib_decode_pkg::*;
    logic clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic [4:0] reg_addr_i = 5'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'h0;
    logic reg_re_i = 1'h0;
    logic dec_valid_i = 1'h0;
    logic addr32_i = 1'h0;
    logic [7:0] modrm_i = 8'h0;
    logic [7:0] sib_i = 8'h0;
    logic [31:0] disp_i = 32'h0;
    logic [7:0][31:0] gpr_i;
    logic seg_wide_valid_i = 1'h0;
    logic seg_narrow_valid_i = 1'h0;
    logic [2:0] segment_select_wide_i = 3'h0;
    logic [1:0] segment_select_narrow_i = 2'h0;
    logic [31:0] reg_rdata_o, ea_o;
    logic ea_valid_o, ea_undef_o, seg_valid_o, invalid_opcode_o;
    logic [2:0] ea_seg_o, seg_o;
    int mismatches = 0;
    int total_checks = 0;

    sib_segment_field_decode_and_id_query u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .dec_valid_i(dec_valid_i), .addr32_i(addr32_i), .modrm_i(modrm_i),
        .sib_i(sib_i), .disp_i(disp_i), .gpr_i(gpr_i), .seg_wide_valid_i(seg_wide_valid_i),
        .segment_select_wide_i(segment_select_wide_i), .seg_narrow_valid_i(seg_narrow_valid_i),
        .segment_select_narrow_i(segment_select_narrow_i), .ea_valid_o(ea_valid_o), .ea_o(ea_o),
        .ea_seg_o(ea_seg_o), .ea_undef_o(ea_undef_o), .seg_valid_o(seg_valid_o), .seg_o(seg_o),
        .invalid_opcode_o(invalid_opcode_o));

    initial forever #25 clk_i = ~clk_i;

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'h0;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk_i);
        reg_re_i <= 1'h1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'h0;
        #1;
        chk(reg_rdata_o & mask, exp);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_seg();
        for (int c = 0; c < 12; c++) begin
            @(posedge clk_i);
            seg_wide_valid_i <= (c < 8);
            segment_select_wide_i <= 3'(c);
            seg_narrow_valid_i <= 1'h1;
            segment_select_narrow_i <= 2'(c + 1);
            @(posedge clk_i);
            seg_wide_valid_i <= 1'h0;
            seg_narrow_valid_i <= 1'h0;
            #1;
            chk(32'({seg_valid_o, invalid_opcode_o, seg_o}), c < 6 ? 32'({2'h2, 3'(c)}) :
                c < 8 ? 32'h0E : 32'({3'h4, 2'(c + 1)}));
        end
        $display("segment selector test done");
    endtask

    task automatic t_sib();
        logic [31:0] exp_ea;
        logic [2:0] ix;
        logic ss;
        for (int m = 0; m < 3; m++) begin
            for (int b = 0; b < 8; b++) begin
                for (int s = 0; s < 4; s++) begin
                    ix = 3'(b + m + s);
                    ss = (b == 4) || (b == 5 && m != 0);
                    exp_ea = ((b == 5 && m == 0) ? 32'h1234_5690 : gpr_i[b])
                        + ((ix == 3'h4) ? 32'h0 : gpr_i[ix] << s)
                        + (m == 1 ? 32'hFFFF_FF90 : m == 2 ? 32'h1234_5690 : 32'h0);
                    @(posedge clk_i);
                    dec_valid_i <= 1'h1;
                    addr32_i <= 1'h1;
                    modrm_i <= {2'(m), 3'h2, 3'h4};
                    sib_i <= {2'(s), ix, 3'(b)};
                    disp_i <= 32'h1234_5690;
                    @(posedge clk_i);
                    dec_valid_i <= 1'h0;
                    #1;
                    chk(32'({ea_valid_o, ea_undef_o, ea_seg_o}), 32'({1'h1, ix == 3'h4 && s != 0, ss ? 3'h2 : 3'h3}));
                    if (ix != 3'h4 || s == 0) chk(ea_o, exp_ea);
                end
            end
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            dec_valid_i <= 1'h1;
            addr32_i <= (k != 2);
            modrm_i <= k == 0 ? 8'hC4 : k == 1 ? 8'h05 : 8'h04;
            @(posedge clk_i);
            dec_valid_i <= 1'h0;
            #1;
            chk(32'(ea_valid_o), 32'h0);
        end
        $display("sib decode test done");
    endtask

    task automatic t_id();
        rdc(REG_STATUS, 32'hC, 32'hC);
        rdc(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
        wr(REG_ID_FUNC, ID_FUNC_INFO);
        #1;
        chk(32'(invalid_opcode_o), 32'h1);
        rdc(REG_ID_EDX, 32'hFFFF_FFFF, 32'h0);
        rdc(REG_STATUS, 32'h3, 32'h2);
        wr(REG_STATUS, 32'hF);
        wr(REG_CTRL, 32'h1);
        wr(REG_ID_FUNC, ID_FUNC_VENDOR);
        #1;
        chk(32'(invalid_opcode_o), 32'h0);
        // Neutral vendor words, first character in the low byte
        rdc(REG_ID_EBX, 32'hFFFF_FFFF, 32'h7475_654E);
        rdc(REG_ID_EDX, 32'hFFFF_FFFF, 32'h436C_6172);
        rdc(REG_ID_ECX, 32'hFFFF_FFFF, 32'h3165_726F);
        wr(REG_ID_FUNC, ID_FUNC_INFO);
        rdc(REG_ID_EAX, 32'h0000_FFFF, 32'h0000_0B0A);
        rdc(REG_ID_EDX, 32'hFFFF_FFFF, 32'h0080_A135);
        // Other functions answer zero; the function word reads back
        wr(REG_ID_FUNC, 32'h0000_0002);
        rdc(REG_ID_EDX, 32'hFFFF_FFFF, 32'h0);
        rdc(REG_ID_FUNC, 32'hFFFF_FFFF, 32'h0000_0002);
        rdc(REG_STATUS, 32'hF, 32'h1);
        rdc(5'h03, 32'hFFFF_FFFF, 32'h0);
        $display("identification test done");
    endtask

    initial begin
        for (int i = 0; i < 8; i++) gpr_i[i] = 32'h0001_0010 * (i + 1);
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'h1;
        t_seg();
        t_sib();
        t_id();
        tally_and_finish();
    end

    // Guard against a hang in any scenario
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end
endmodule

bind sib_segment_field_decode_and_id_query sib_decode_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .dec_valid_i(dec_valid_i), .addr32_i(addr32_i), .modrm_i(modrm_i), .sib_i(sib_i),
    .seg_wide_valid_i(seg_wide_valid_i), .segment_select_wide_i(segment_select_wide_i),
    .seg_narrow_valid_i(seg_narrow_valid_i), .segment_select_narrow_i(segment_select_narrow_i),
    .ea_valid_o(ea_valid_o), .ea_seg_o(ea_seg_o), .ea_undef_o(ea_undef_o), .seg_valid_o(seg_valid_o),
    .seg_o(seg_o), .invalid_opcode_o(invalid_opcode_o));
`default_nettype wire
